// ### verilog/ipc_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * idle/power-down controller. Assumes a 200 MHz oscillator clock on I_CLK.
 */
// Contract
// - idle bit write is last instruction
// - idle gates CPU clock only
// - idle preserves CPU state and pins
// - idle drives both strobes high
// - enabled interrupt clears idle, resumes after
// - two general flags for handler inspection
// - reset of 24 clocks ends idle
// - power-down stops oscillator after request
// - power-down retains RAM and registers
// - only enabled ext/keyboard interrupts wake
// - keyboard wake waits 1024 clocks
// - pin low restarts oscillator, high exits
// - first release exits, higher priority serviced
// - reset exit reinitialises registers, interrupt not
// - both bits cleared on vectoring, no idle
// - strobes 1 idle, 0 power-down; port states
// - port 0 drives only low when asleep
// - reset length independent of clock mode
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH

`define IPC_OFS_PWR_CTRL   12'h000
`define IPC_OFS_WAKE_CFG   12'h004
`define IPC_OFS_STATUS     12'h008
`define IPC_OFS_PORT_DATA  12'h00c

`define IPC_PWR_IDLE_BIT   0
`define IPC_PWR_DOWN_BIT   1
`define IPC_PWR_FLAG0_BIT  2
`define IPC_PWR_FLAG1_BIT  3

`define IPC_CFG_EN_EXT0    0
`define IPC_CFG_EN_EXT1    1
`define IPC_CFG_EN_KBD     2
`define IPC_CFG_PRIO_EXT1  3
`define IPC_CFG_EXT_PMEM   4

`define IPC_PWR_RESET      4'h0
`define IPC_CFG_RESET      5'h00
`define IPC_PORT_RESET     32'hffffffff

`define IPC_RST_MIN_CLKS   5'd24
`define IPC_KBD_WAIT_CLKS  11'd1024

`endif

// ### verilog/ipc_pkg.sv
/*
 * Types shared by the idle/power-down controller.
 * Assumes ipc_map.svh holds the numeric constants.
 */
package ipc_pkg;

	// gray along run -> stop -> osc restart; idle and keyboard wait off path
	typedef enum logic [2:0] {
		ST_RUN      = 3'b000,
		ST_DN_STOP  = 3'b001,
		ST_DN_OSC   = 3'b011,
		ST_KBD_WAIT = 3'b010,
		ST_IDLE     = 3'b100
	} ipc_state_type;

	typedef enum logic [1:0] {
		MODE_RUN  = 2'h0,
		MODE_IDLE = 2'h1,
		MODE_DOWN = 2'h2
	} ipc_mode_type;

	typedef enum logic [1:0] {
		WAKE_NONE = 2'h0,
		WAKE_EXT0 = 2'h1,
		WAKE_EXT1 = 2'h2,
		WAKE_KBD  = 2'h3
	} ipc_wake_type;

endpackage

// ### verilog/ipc_rst_filter.sv
/*
 * Reset pin qualifier: passes the hardware reset on only after the pin
 * has been high for the minimum number of oscillator clocks.
 * Assumes the pin is synchronous to I_CLK.
 */
`timescale 1ns/1ps
`include "ipc_map.svh"

module ipc_rst_filter
	import ipc_pkg::*;
(
	// clock and reset
	input  logic i_clk,
	input  logic i_nrst,
	// reset pin and qualified reset
	input  logic i_rst_pin,
	output logic o_core_rst
);

	logic [4:0] cnt_ff;
	logic       rst_ff;

	// same count in single- and double-speed mode: counts oscillator clocks
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_ff <= 5'h00;
		end else if (!i_rst_pin) begin
			cnt_ff <= 5'h00;
		end else if (cnt_ff != `IPC_RST_MIN_CLKS) begin
			cnt_ff <= cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_ff <= 1'b0;
		end else begin
			rst_ff <= i_rst_pin && (cnt_ff >= (`IPC_RST_MIN_CLKS - 5'h01));
		end
	end

	assign o_core_rst = rst_ff;

	chk_rst_after_min: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_rst_pin [*8] ##0 (cnt_ff == 5'd23) |=> o_core_rst)
		else $error("reset not taken after 24 clocks");

	chk_rst_not_early: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(cnt_ff < 5'd23) |=> !o_core_rst)
		else $error("reset taken before 24 clocks");

endmodule

// ### verilog/ipc_port_pin.sv
/*
 * Next-state pin drive for one 8-bit port in run, idle and power-down.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps

module ipc_port_pin
	import ipc_pkg::*;
#(
	parameter int KIND = 1
) (
	// mode and memory setup
	input  ipc_mode_type i_mode,
	input  logic         i_ext_pmem,
	// data sources
	input  logic [7:0]   i_data,
	input  logic [7:0]   i_addr,
	// pin drive
	output logic [7:0]   o_out,
	output logic [7:0]   o_oe
);

	always_comb begin
		o_out = i_data;
		o_oe  = 8'hff;
		if (KIND == 0) begin
			if (i_ext_pmem) begin
				o_out = 8'h00; // float during external fetch
				o_oe  = 8'h00;
			end else if (i_mode != MODE_RUN) begin
				o_out = 8'h00; // only zeros driven, ones float
				o_oe  = ~i_data;
			end
		end else if (KIND == 2) begin
			if (i_ext_pmem && i_mode == MODE_IDLE) begin
				o_out = i_addr;
			end
		end
	end

endmodule

// ### verilog/ipc_top.sv
/*
 * Idle and power-down controller: APB registers, power mode state machine,
 * wake-up from external and keyboard interrupts, strobe and port pin states.
 * Assumes all inputs synchronous to I_CLK; the core honours O_CPU_CLK_EN.
 */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ipc_map.svh"

module ipc_top
	import ipc_pkg::*;
(
	// clock and reset
	input  logic        I_CLK,
	input  logic        I_NRST,
	input  logic        I_RST_PIN,
	// apb slave
	input  logic        I_PSEL,
	input  logic        I_PENABLE,
	input  logic        I_PWRITE,
	input  logic [11:0] I_PADDR,
	input  logic [31:0] I_PWDATA,
	output logic        O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic        O_PSLVERR,
	// core side
	input  logic        I_IRQ_PEND,
	input  logic        I_ALE_RUN,
	input  logic        I_PROG_STB_RUN,
	input  logic [7:0]  I_FETCH_ADDR_HI,
	// wake-up pins
	input  logic        I_EXT_IRQ_ZERO_N,
	input  logic        I_EXTERNAL_IRQ_ONE_N,
	input  logic        I_KBD_IRQ,
	// clock gating and reset out
	output logic        O_CPU_CLK_EN,
	output logic        O_PERIPH_CLK_EN,
	output logic        O_OSC_EN,
	output logic        O_CORE_RST,
	output logic [1:0]  O_WAKE_SRC,
	// strobes
	output logic        O_ADDR_LATCH_STB,
	output logic        O_PROGRAM_STORE_STB,
	// ports
	output logic [31:0] O_PORT_OUT,
	output logic [31:0] O_PORT_OE
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	ipc_state_type state_ff;
	ipc_state_type nxt_state;
	ipc_mode_type  nxt_mode;
	ipc_wake_type  wake_ff;
	ipc_wake_type  nxt_wake;
	logic        core_rst;
	logic        idle_request_bit_ff;
	logic        powerdown_request_bit_ff;
	logic        general_flag_zero_ff;
	logic        general_flag_one_ff;
	logic [4:0]  cfg_ff;
	logic [31:0] port_data_ff;
	logic [10:0] kbd_cnt_ff;
	logic        setup;
	logic        wr_en;
	logic        wr_pwr;
	logic        hw_clear;
	logic        ext0_low;
	logic        ext1_low;
	logic        ext0_rel;
	logic        ext1_rel;
	logic        kbd_wake;
	logic        ext0_was_high;
	logic        ext1_was_high;
	logic        mapped;
	logic [31:0] rd_data;
	logic [31:0] nxt_port_out;
	logic [31:0] nxt_port_oe;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic        cpu_en_ff;
	logic        periph_en_ff;
	logic        osc_en_ff;
	logic        ale_ff;
	logic        prog_stb_ff;
	logic [31:0] port_out_ff;
	logic [31:0] port_oe_ff;
	logic        core_rst_ff;

	////////////////////////////////////////////////////////////////////////////////
	// hardware reset pin

	ipc_rst_filter u_rst_filter (
		.i_clk      (I_CLK),
		.i_nrst     (I_NRST),
		.i_rst_pin  (I_RST_PIN),
		.o_core_rst (core_rst)
	);

	////////////////////////////////////////////////////////////////////////////////
	// apb slave, one wait-free access cycle

	assign setup  = I_PSEL && !I_PENABLE;
	assign wr_en  = I_PSEL && I_PENABLE && pready_ff && I_PWRITE && !pslverr_ff;
	assign wr_pwr = wr_en && (I_PADDR == `IPC_OFS_PWR_CTRL);
	assign mapped = (I_PADDR == `IPC_OFS_PWR_CTRL) || (I_PADDR == `IPC_OFS_WAKE_CFG) ||
		(I_PADDR == `IPC_OFS_STATUS) || (I_PADDR == `IPC_OFS_PORT_DATA);

	always_comb begin
		rd_data = 32'h00000000;
		unique case (I_PADDR)
			`IPC_OFS_PWR_CTRL:  rd_data[3:0] = {general_flag_one_ff, general_flag_zero_ff,
				powerdown_request_bit_ff, idle_request_bit_ff};
			`IPC_OFS_WAKE_CFG:  rd_data[4:0] = cfg_ff;
			`IPC_OFS_STATUS: begin
				rd_data[6]   = osc_en_ff;
				rd_data[4:0] = {wake_ff, state_ff};
			end
			`IPC_OFS_PORT_DATA: rd_data = port_data_ff;
			default:            rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !mapped;
			if (setup) begin
				prdata_ff <= rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power control register

	// vectoring to the wake interrupt clears both request bits
	assign hw_clear = (state_ff == ST_IDLE && I_IRQ_PEND) ||
		(state_ff == ST_DN_OSC && (ext0_rel || ext1_rel)) ||
		(state_ff == ST_KBD_WAIT && kbd_cnt_ff == (`IPC_KBD_WAIT_CLKS - 11'h001));

	// software sets only; a set in the clearing cycle wins
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			idle_request_bit_ff      <= 1'b0;
			powerdown_request_bit_ff <= 1'b0;
		end else if (core_rst) begin
			idle_request_bit_ff      <= 1'b0;
			powerdown_request_bit_ff <= 1'b0;
		end else if (wr_pwr || hw_clear) begin
			idle_request_bit_ff      <= (idle_request_bit_ff && !hw_clear) ||
				(wr_pwr && I_PWDATA[`IPC_PWR_IDLE_BIT]);
			powerdown_request_bit_ff <= (powerdown_request_bit_ff && !hw_clear) ||
				(wr_pwr && I_PWDATA[`IPC_PWR_DOWN_BIT]);
		end
	end

	// flags, config and port data: reset reinitialises, wake-up leaves untouched
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			general_flag_zero_ff <= 1'b0;
			general_flag_one_ff  <= 1'b0;
		end else if (core_rst) begin
			general_flag_zero_ff <= 1'b0;
			general_flag_one_ff  <= 1'b0;
		end else if (wr_pwr) begin
			general_flag_zero_ff <= I_PWDATA[`IPC_PWR_FLAG0_BIT];
			general_flag_one_ff  <= I_PWDATA[`IPC_PWR_FLAG1_BIT];
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cfg_ff <= `IPC_CFG_RESET;
		end else if (core_rst) begin
			cfg_ff <= `IPC_CFG_RESET;
		end else if (wr_en && I_PADDR == `IPC_OFS_WAKE_CFG) begin
			cfg_ff <= I_PWDATA[4:0];
		end
	end

	// port data frozen while the core is stopped
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			port_data_ff <= `IPC_PORT_RESET;
		end else if (core_rst) begin
			port_data_ff <= `IPC_PORT_RESET;
		end else if (wr_en && I_PADDR == `IPC_OFS_PORT_DATA && state_ff == ST_RUN) begin
			port_data_ff <= I_PWDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power mode state machine

	// only enabled external and keyboard interrupts wake from power-down
	assign ext0_low = cfg_ff[`IPC_CFG_EN_EXT0] && !I_EXT_IRQ_ZERO_N;
	assign ext1_low = cfg_ff[`IPC_CFG_EN_EXT1] && !I_EXTERNAL_IRQ_ONE_N;
	assign kbd_wake = cfg_ff[`IPC_CFG_EN_KBD] && I_KBD_IRQ;
	// release of any enabled pin that went low during power-down completes the exit
	assign ext0_rel = (wake_ff == WAKE_EXT0 || wake_ff == WAKE_EXT1) &&
		cfg_ff[`IPC_CFG_EN_EXT0] && I_EXT_IRQ_ZERO_N && !ext0_was_high;
	assign ext1_rel = (wake_ff == WAKE_EXT0 || wake_ff == WAKE_EXT1) &&
		cfg_ff[`IPC_CFG_EN_EXT1] && I_EXTERNAL_IRQ_ONE_N && !ext1_was_high;

	// pins still high when the oscillator restarted do not count as a release
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ext0_was_high <= 1'b1;
			ext1_was_high <= 1'b1;
		end else if (state_ff == ST_DN_STOP) begin
			ext0_was_high <= !ext0_low;
			ext1_was_high <= !ext1_low;
		end else if (state_ff == ST_DN_OSC) begin
			ext0_was_high <= ext0_was_high && !ext0_low;
			ext1_was_high <= ext1_was_high && !ext1_low;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_wake  = wake_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (powerdown_request_bit_ff) begin
					nxt_state = ST_DN_STOP; // power-down wins over idle
				end else if (idle_request_bit_ff) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (I_IRQ_PEND) begin
					nxt_state = ST_RUN;
				end
			end
			ST_DN_STOP: begin
				if (ext0_low || ext1_low) begin
					nxt_state = ST_DN_OSC;
					nxt_wake  = ext0_low ? WAKE_EXT0 : WAKE_EXT1;
				end else if (kbd_wake) begin
					nxt_state = ST_KBD_WAIT;
					nxt_wake  = WAKE_KBD;
				end
			end
			ST_DN_OSC: begin
				if (ext0_rel || ext1_rel) begin
					nxt_state = ST_RUN;
					if (ext0_rel && ext1_rel) begin
						nxt_wake = cfg_ff[`IPC_CFG_PRIO_EXT1] ? WAKE_EXT1 : WAKE_EXT0;
					end else begin
						nxt_wake = ext0_rel ? WAKE_EXT0 : WAKE_EXT1;
					end
				end
			end
			ST_KBD_WAIT: begin
				if (kbd_cnt_ff == (`IPC_KBD_WAIT_CLKS - 11'h001)) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_ff <= ST_RUN;
			wake_ff  <= WAKE_NONE;
		end else if (core_rst) begin
			state_ff <= ST_RUN; // reset ends idle and power-down
			wake_ff  <= WAKE_NONE;
		end else begin
			state_ff <= nxt_state;
			wake_ff  <= nxt_wake;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			kbd_cnt_ff <= 11'h000;
		end else if (state_ff == ST_KBD_WAIT && !core_rst) begin
			kbd_cnt_ff <= kbd_cnt_ff + 11'h001;
		end else begin
			kbd_cnt_ff <= 11'h000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock enables, strobes and pins, all registered from the next state

	assign nxt_mode = (nxt_state == ST_RUN) ? MODE_RUN :
		(nxt_state == ST_IDLE) ? MODE_IDLE : MODE_DOWN;

	for (genvar g = 0; g < 4; g++) begin : g_port
		ipc_port_pin #(.KIND(g)) u_port (
			.i_mode     (core_rst ? MODE_RUN : nxt_mode),
			.i_ext_pmem (cfg_ff[`IPC_CFG_EXT_PMEM]),
			.i_data     (port_data_ff[8*g +: 8]),
			.i_addr     (I_FETCH_ADDR_HI),
			.o_out      (nxt_port_out[8*g +: 8]),
			.o_oe       (nxt_port_oe[8*g +: 8])
		);
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cpu_en_ff    <= 1'b1;
			periph_en_ff <= 1'b1;
			osc_en_ff    <= 1'b1;
		end else begin
			cpu_en_ff    <= core_rst || nxt_mode == MODE_RUN;
			periph_en_ff <= core_rst || nxt_mode != MODE_DOWN;
			// oscillator stopped only while waiting for a wake-up
			osc_en_ff    <= core_rst || nxt_state != ST_DN_STOP;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ale_ff      <= 1'b0;
			prog_stb_ff <= 1'b0;
		end else if (core_rst || nxt_mode == MODE_RUN) begin
			ale_ff      <= I_ALE_RUN;
			prog_stb_ff <= I_PROG_STB_RUN;
		end else begin
			ale_ff      <= (nxt_mode == MODE_IDLE);
			prog_stb_ff <= (nxt_mode == MODE_IDLE);
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			port_out_ff <= 32'h00000000;
			port_oe_ff  <= 32'h00000000;
			core_rst_ff <= 1'b0;
		end else begin
			port_out_ff <= nxt_port_out;
			port_oe_ff  <= nxt_port_oe;
			core_rst_ff <= core_rst;
		end
	end

	assign O_PREADY            = pready_ff;
	assign O_PRDATA            = prdata_ff;
	assign O_PSLVERR           = pslverr_ff;
	assign O_CPU_CLK_EN        = cpu_en_ff;
	assign O_PERIPH_CLK_EN     = periph_en_ff;
	assign O_OSC_EN            = osc_en_ff;
	assign O_CORE_RST          = core_rst_ff;
	assign O_WAKE_SRC          = wake_ff;
	assign O_ADDR_LATCH_STB    = ale_ff;
	assign O_PROGRAM_STORE_STB = prog_stb_ff;
	assign O_PORT_OUT          = port_out_ff;
	assign O_PORT_OE           = port_oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_idle_req;
		wr_pwr && I_PWDATA[0] && !I_PWDATA[1] && state_ff == ST_RUN && !core_rst;
	endsequence

	sequence s_idle_in;
		(state_ff == ST_IDLE) && !O_CPU_CLK_EN && O_PERIPH_CLK_EN;
	endsequence

	chk_idle_entry: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		s_idle_req ##1 (!core_rst && !powerdown_request_bit_ff) |=> s_idle_in)
		else $error("idle not entered after request");

	chk_idle_strobes: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_ff == ST_IDLE) |-> O_ADDR_LATCH_STB && O_PROGRAM_STORE_STB)
		else $error("strobes not high in idle");

	chk_down_strobes: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_ff == ST_DN_STOP) |-> !O_ADDR_LATCH_STB && !O_PROGRAM_STORE_STB && !O_OSC_EN)
		else $error("strobes or oscillator wrong in power-down");

	chk_idle_exit: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_ff == ST_IDLE && I_IRQ_PEND && !wr_pwr) |=> state_ff == ST_RUN && !idle_request_bit_ff)
		else $error("idle not left on interrupt");

	chk_down_exit: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_ff == ST_DN_OSC && (ext0_rel || ext1_rel) && !wr_pwr && !core_rst)
		|=> state_ff == ST_RUN && !idle_request_bit_ff && !powerdown_request_bit_ff)
		else $error("power-down exit left request bits or state");

	chk_kbd_wait: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_ff == ST_KBD_WAIT && !core_rst) |=>
		(state_ff == ST_RUN) == ($past(kbd_cnt_ff) == 11'd1023))
		else $error("keyboard wake wait not 1024 clocks");

	chk_port0_open: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_ff != ST_RUN && !core_rst_ff && !cfg_ff[`IPC_CFG_EXT_PMEM] && $stable(cfg_ff))
		|-> O_PORT_OUT[7:0] == 8'h00 && O_PORT_OE[7:0] == ~port_data_ff[7:0])
		else $error("port 0 drives a one while asleep");

	chk_reset_clears: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		core_rst |=> !idle_request_bit_ff && !powerdown_request_bit_ff && state_ff == ST_RUN)
		else $error("reset left power request set");

	chk_sw_only_set: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		$rose(idle_request_bit_ff) || $rose(powerdown_request_bit_ff) |-> $past(wr_pwr))
		else $error("request bit set without software write");

endmodule

// ### tb/ipc_wake_model.sv
/*
 * Far-side pin model: external wake pins, keyboard wake and reset pin.
 * Assumes the bench calls its tasks; pins change just after a rising edge.
 */
`timescale 1ns/1ps

module ipc_wake_model (
	// clock
	input  wire logic i_clk,
	// pins toward the controller
	output logic      o_ext0_n,
	output logic      o_ext1_n,
	output logic      o_kbd,
	output logic      o_rst_pin
);
	initial begin
		o_ext0_n  = 1'b1;
		o_ext1_n  = 1'b1;
		o_kbd     = 1'b0;
		o_rst_pin = 1'b0;
	end

	// wake pin held low long enough for the oscillator to restart
	task automatic hold_ext(input int which, input int cycles);
		@(posedge i_clk);
		if (which == 0) o_ext0_n <= 1'b0;
		else o_ext1_n <= 1'b0;
		repeat (cycles) @(posedge i_clk);
		o_ext0_n <= 1'b1;
		o_ext1_n <= 1'b1;
	endtask

	task automatic pulse_kbd();
		@(posedge i_clk);
		o_kbd <= 1'b1;
		@(posedge i_clk);
		o_kbd <= 1'b0;
	endtask

	task automatic hold_rst(input int cycles);
		@(posedge i_clk);
		o_rst_pin <= 1'b1;
		repeat (cycles) @(posedge i_clk);
		o_rst_pin <= 1'b0;
	endtask
endmodule

// ### tb/ipc_top_tb.sv
/*
 * Self-checking bench for the idle/power-down controller.
 * Assumes nothing of APB wait states; wake pins from ipc_wake_model.
 */
`timescale 1ns/1ps
`include "ipc_map.svh"

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end

module ipc_top_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        irq_pend = 1'b0;
	logic        ale_run = 1'b1;
	logic        prog_stb_run = 1'b0;
	logic [7:0]  fetch_hi = 8'h3c;
	wire         ext0_n, ext1_n, kbd, rst_pin;
	logic        pready, pslverr, cpu_en, per_en, osc_en, core_rst, ale, prog_stb;
	logic [31:0] prdata, port_out, port_oe;
	logic [1:0]  wake;
	logic [31:0] rdat;
	logic        rerr;
	logic        rst_seen = 1'b0;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n;

	always #2.5 clk = ~clk;

	ipc_wake_model u_ipc_wake_model (.i_clk(clk), .o_ext0_n(ext0_n), .o_ext1_n(ext1_n), .o_kbd(kbd),
		.o_rst_pin(rst_pin));

	ipc_top u_ipc_top (.I_CLK(clk), .I_NRST(nrst), .I_RST_PIN(rst_pin), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
		.O_PSLVERR(pslverr), .I_IRQ_PEND(irq_pend), .I_ALE_RUN(ale_run), .I_PROG_STB_RUN(prog_stb_run),
		.I_FETCH_ADDR_HI(fetch_hi), .I_EXT_IRQ_ZERO_N(ext0_n), .I_EXTERNAL_IRQ_ONE_N(ext1_n),
		.I_KBD_IRQ(kbd), .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_OSC_EN(osc_en),
		.O_CORE_RST(core_rst), .O_WAKE_SRC(wake), .O_ADDR_LATCH_STB(ale), .O_PROGRAM_STORE_STB(prog_stb),
		.O_PORT_OUT(port_out), .O_PORT_OE(port_oe));

	always @(posedge clk) begin
		if (core_rst === 1'b1) rst_seen <= 1'b1;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// apb master: hold the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rdat)
	endtask

	task automatic settle(input int c);
		repeat (c) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(`IPC_OFS_PWR_CTRL, 32'h0, "pwr reset");
		`CHK("strobes run", 2'b10, {ale, prog_stb})
		rd_chk(`IPC_OFS_PORT_DATA, 32'hffffffff, "port reset");
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped err", 1'b1, rerr)
		apb(1'b1, `IPC_OFS_PORT_DATA, 32'h123456a5);
		apb(1'b1, `IPC_OFS_WAKE_CFG, 32'h10);
		// idle with external program memory, both flags set
		apb(1'b1, `IPC_OFS_PWR_CTRL, 32'hd);
		settle(3);
		`CHK("cpu en idle", 1'b0, cpu_en)
		`CHK("periph en idle", 1'b1, per_en)
		`CHK("strobes idle", 2'b11, {ale, prog_stb})
		`CHK("port1 idle", 8'h56, port_out[15:8])
		`CHK("port2 idle", fetch_hi, port_out[23:16])
		`CHK("port0 oe idle", 8'h00, port_oe[7:0])
		apb(1'b1, `IPC_OFS_PWR_CTRL, 32'hc);
		settle(3);
		`CHK("cpu en sw clear", 1'b0, cpu_en)
		@(posedge clk) irq_pend <= 1'b1;
		@(posedge clk) irq_pend <= 1'b0;
		settle(2);
		`CHK("cpu en wake", 1'b1, cpu_en)
		rd_chk(`IPC_OFS_PWR_CTRL, 32'hc, "flags kept");
		// power-down with idle too, only ext1 enabled
		apb(1'b1, `IPC_OFS_WAKE_CFG, 32'h02);
		apb(1'b1, `IPC_OFS_PWR_CTRL, 32'hf);
		settle(3);
		`CHK("osc pd", 1'b0, osc_en)
		`CHK("strobes pd", 2'b00, {ale, prog_stb})
		`CHK("periph en pd", 1'b0, per_en)
		`CHK("port0 oe pd", 8'h5a, port_oe[7:0])
		`CHK("port0 high pd", 8'h00, port_out[7:0] & port_oe[7:0])
		u_ipc_wake_model.hold_ext(0, 10);
		settle(3);
		`CHK("osc disabled pin", 1'b0, osc_en)
		apb(1'b1, `IPC_OFS_PORT_DATA, 32'h0);
		rd_chk(`IPC_OFS_PORT_DATA, 32'h123456a5, "port kept pd");
		rd_chk(`IPC_OFS_STATUS, 32'h00000001, "status pd");
		fork
			u_ipc_wake_model.hold_ext(1, 20);
			begin
				settle(10);
				`CHK("osc restart", 2'b10, {osc_en, cpu_en})
			end
		join
		settle(4);
		`CHK("cpu en pd exit", 1'b1, cpu_en)
		`CHK("wake ext1", 2'd2, wake)
		rd_chk(`IPC_OFS_PWR_CTRL, 32'hc, "bits cleared");
		rd_chk(`IPC_OFS_WAKE_CFG, 32'h02, "cfg kept");
		// keyboard wake
		apb(1'b1, `IPC_OFS_WAKE_CFG, 32'h04);
		apb(1'b1, `IPC_OFS_PWR_CTRL, 32'h2);
		settle(3);
		u_ipc_wake_model.pulse_kbd();
		n = 0;
		while (cpu_en !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		`CHK("kbd wait", 1'b1, n >= 1024 && n <= 1030)
		`CHK("wake kbd", 2'd3, wake)
		// reset pin in idle: 23 clocks too short, a longer one resets
		apb(1'b1, `IPC_OFS_PWR_CTRL, 32'h1);
		settle(3);
		u_ipc_wake_model.hold_rst(23);
		settle(3);
		`CHK("short rst", 2'b00, {rst_seen, cpu_en})
		u_ipc_wake_model.hold_rst(30);
		settle(3);
		`CHK("long rst", 2'b11, {rst_seen, cpu_en})
		rd_chk(`IPC_OFS_PWR_CTRL, 32'h0, "pwr after rst");
		rd_chk(`IPC_OFS_PORT_DATA, 32'hffffffff, "port after rst");
		final_report();
	end
endmodule
